/* inc/stc_timer_regs.vh */
`ifndef STC_TIMER_REGS_VH
`define STC_TIMER_REGS_VH

// Register addresses (chosen; index on the plain port)
`define STC_ADDR_W        2
`define STC_ADDR_CTRL     2'h0
`define STC_ADDR_COUNT    2'h1
`define STC_ADDR_PERIOD   2'h2
`define STC_ADDR_STATUS   2'h3

// Control register layout
`define STC_BIT_RUN       15
`define STC_BIT_IDLE_HALT 13
`define STC_BIT_GATE      6
`define STC_BIT_PS_HI     5
`define STC_BIT_PS_LO     4
`define STC_BIT_CSRC      1
`define STC_CTRL_MASK     16'hA072
`define STC_CTRL_RESET    16'h0000
`define STC_COUNT_RESET   16'h0000
`define STC_PERIOD_RESET  16'hFFFF

// Status register layout
`define STC_BIT_FLAG      0

// Prescale codes
`define STC_PS_1          2'h0
`define STC_PS_8          2'h1
`define STC_PS_64         2'h2
`define STC_PS_256        2'h3
`define STC_PS_CNT_W      8
`define STC_PS_TC_8       8'h07
`define STC_PS_TC_64      8'h3F
`define STC_PS_TC_256     8'hFF

// Instruction cycle is one clock at 25 MHz core rate
`define STC_OSC_PER_CYCLE 4

`endif

/* rtl/stc_prescale.v */
`timescale 1ns/100ps
`include "stc_timer_regs.vh"
// Prescaler: passes every 1st, 8th, 64th or 256th input tick
module stc_prescale (
  input  wire       i_clk,
  input  wire       i_sys_rst,
  input  wire       i_clear,
  input  wire       i_tick,
  input  wire [1:0] i_select,
  output wire       o_tick
);
  reg  [`STC_PS_CNT_W-1:0] cnt_reg;
  reg  [`STC_PS_CNT_W-1:0] cnt_next;
  reg  [`STC_PS_CNT_W-1:0] terminal;
  wire                     at_end;

  always @* begin
    case (i_select)
      `STC_PS_8:   terminal = `STC_PS_TC_8;
      `STC_PS_64:  terminal = `STC_PS_TC_64;
      `STC_PS_256: terminal = `STC_PS_TC_256;
      default:     terminal = {`STC_PS_CNT_W{1'b0}};
    endcase
  end

  assign at_end = (cnt_reg >= terminal);
  assign o_tick = i_tick & at_end;

  always @* begin
    cnt_next = cnt_reg;
    if (i_clear)
      cnt_next = {`STC_PS_CNT_W{1'b0}};
    else if (i_tick)
      cnt_next = at_end ? {`STC_PS_CNT_W{1'b0}} : cnt_reg + 8'h01;
  end

  always @(posedge i_clk) begin
    if (i_sys_rst)
      cnt_reg <= {`STC_PS_CNT_W{1'b0}};
    else
      cnt_reg <= cnt_next;
  end
endmodule

/* rtl/stc_sync.v */
`timescale 1ns/100ps
// Two-sample synchroniser with rising and falling edge detection
module stc_sync (
  input  wire i_clk,
  input  wire i_sys_rst,
  input  wire i_enable,
  input  wire i_pin,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  // Pin is sampled once per instruction cycle into meta; sync resamples meta a cycle later.
  // Disabled sampling models the synchroniser powered down in Sleep.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (i_enable) begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign o_level = sync_reg;
  assign o_rise  = i_enable & sync_reg & ~last_reg;
  assign o_fall  = i_enable & ~sync_reg & last_reg;
endmodule

/* rtl/stc_timer.v */
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "stc_timer_regs.vh"
// Function
// - Run bit 15 starts or stops counting
// - Idle-halt bit 13 stops timer in Idle
// - Gate bit 6 reads zero with external clock
// - Prescale bits 5-4 select 1,8,64,256
// - Unimplemented control bits read as zero
// - Bit 1 selects pin or internal clock
// - Internal 1:1 counts once per cycle
// - Sync select has no internal-clock effect
// - External source counts pin rising edges
// - Type C always synchronises count input
// - Pin sampled at two points per cycle (here sampled once per clock into meta_reg)
// - Synchronised counting stops during Sleep
// - Type A unsynchronised counts asynchronously
// - Asynchronous mode runs and wakes in Sleep
// - No asynchronous mode on type C
// - Gated mode counts while pin high
// - Flag on match, or gate fall
// - Prescaler clears on count write, stop
module stc_timer (
  input  wire                   i_clk,
  input  wire                   i_sys_rst,
  input  wire [`STC_ADDR_W-1:0] i_addr,
  input  wire [15:0]            i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [15:0]            o_rdata,
  input  wire                   i_count_input_pin,
  input  wire                   i_idle_mode,
  input  wire                   i_sleep_mode,
  output wire                   o_timer_event_flag,
  output wire                   o_gate_sampled
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [15:0] ctrl_reg;
  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg  [15:0] period_reg;
  reg         flag_reg;
  reg         flag_next;

  wire run_bit                 = ctrl_reg[`STC_BIT_RUN];
  wire idle_halt_bit           = ctrl_reg[`STC_BIT_IDLE_HALT];
  wire clock_source_select     = ctrl_reg[`STC_BIT_CSRC];
  wire gated_accumulate_enable = ctrl_reg[`STC_BIT_GATE] & ~clock_source_select;
  wire [1:0] prescale_select   = ctrl_reg[`STC_BIT_PS_HI:`STC_BIT_PS_LO];

  wire wr_ctrl   = i_wr & (i_addr == `STC_ADDR_CTRL);
  wire wr_count  = i_wr & (i_addr == `STC_ADDR_COUNT);
  wire wr_period = i_wr & (i_addr == `STC_ADDR_PERIOD);
  wire wr_status = i_wr & (i_addr == `STC_ADDR_STATUS);

  // ----------------------------------------
  // Enable conditions
  // ----------------------------------------
  // idle halt
  wire idle_stop = i_idle_mode & idle_halt_bit;
  // no bypass, so Sleep always halts this type
  wire sync_on   = ~i_sleep_mode;
  wire active    = run_bit & ~idle_stop & ~i_sleep_mode;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  wire pin_level;
  wire pin_rise;
  wire pin_fall;

  stc_sync u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (sync_on),
    .i_pin     (i_count_input_pin),
    .o_level   (pin_level),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  assign o_gate_sampled = pin_level;

  // ----------------------------------------
  // Input tick selection
  // ----------------------------------------
  // source select
  // gate passes ticks while pin high
  reg raw_tick;
  always @* begin
    if (!active)
      raw_tick = 1'b0;
    else if (clock_source_select)
      raw_tick = pin_rise;
    else if (gated_accumulate_enable)
      raw_tick = pin_level;
    else
      raw_tick = 1'b1;
  end

  wire ps_clear = wr_count | ~run_bit;
  wire count_tick;

  stc_prescale u_prescale (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (ps_clear),
    .i_tick    (raw_tick),
    .i_select  (prescale_select),
    .o_tick    (count_tick)
  );

  // ----------------------------------------
  // Count register
  // ----------------------------------------
  wire at_period = (count_reg == period_reg);

  always @* begin
    count_next = count_reg;
    if (wr_count)
      count_next = i_wdata;
    else if (count_tick) begin
      if (at_period)
        count_next = 16'h0000;
      else
        count_next = count_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Event flag
  // ----------------------------------------
  // Match raises flag on the tick that wraps, once per period, except in gated mode.
  wire match_evt = count_tick & at_period & ~gated_accumulate_enable;
  // Gate fall only counts when the timer is actually running.
  wire gate_evt  = active & gated_accumulate_enable & pin_fall;

  always @* begin
    flag_next = flag_reg;
    if (wr_status & ~i_wdata[`STC_BIT_FLAG])
      flag_next = 1'b0;
    if (match_evt | gate_evt)
      flag_next = 1'b1;
  end

  assign o_timer_event_flag = flag_reg;

  // ----------------------------------------
  // Sequential state
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg   <= `STC_CTRL_RESET;
      count_reg  <= `STC_COUNT_RESET;
      period_reg <= `STC_PERIOD_RESET;
      flag_reg   <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= i_wdata & `STC_CTRL_MASK;
      if (wr_period)
        period_reg <= i_wdata;
      count_reg <= count_next;
      flag_reg  <= flag_next;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    case (i_addr)
      `STC_ADDR_CTRL: begin
        rd_mux = ctrl_reg;
        rd_mux[`STC_BIT_GATE] = gated_accumulate_enable;
      end
      `STC_ADDR_COUNT:  rd_mux = count_reg;
      `STC_ADDR_PERIOD: rd_mux = period_reg;
      `STC_ADDR_STATUS: rd_mux = {15'h0000, flag_reg};
      default:          rd_mux = 16'h0000;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_sys_rst)
      o_rdata <= 16'h0000;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 16'h0000;
  end
endmodule

/* testbench/stc_pin_source.sv */
`timescale 1ns/100ps
// Far-side pin driver: a burst of pulses, else a plain level
module stc_pin_source (
  input  wire       i_clk,
  input  wire       i_load,
  input  wire [3:0] i_pulses,
  input  wire       i_level,
  output reg        o_pin
);
  reg [3:0] left = 4'h0;
  reg [2:0] ph   = 3'h0;
  initial o_pin = 1'b0;
  always @(posedge i_clk) begin
    if (i_load) begin
      left <= i_pulses;
    end else if (left != 4'h0) begin
      ph    <= ph + 3'h1;
      o_pin <= (ph < 3'h3);
      if (ph == 3'h7) begin
        left <= left - 4'h1;
      end
    end else begin
      o_pin <= i_level;
    end
  end
endmodule

/* testbench/stc_timer_checker.sv */
`timescale 1ns/100ps
`include "stc_timer_regs.vh"
module stc_timer_checker (
  input wire                   i_clk,
  input wire                   i_sys_rst,
  input wire [`STC_ADDR_W-1:0] i_addr,
  input wire [15:0]            i_wdata,
  input wire                   i_wr,
  input wire                   i_rd,
  input wire [15:0]            o_rdata,
  input wire                   i_count_input_pin,
  input wire                   i_idle_mode,
  input wire                   i_sleep_mode,
  input wire                   o_timer_event_flag,
  input wire                   o_gate_sampled
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr_ctrl; i_wr && i_addr == `STC_ADDR_CTRL; endsequence
  sequence s_rd_ctrl; i_rd && i_addr == `STC_ADDR_CTRL; endsequence
  AST_UNIMPL: assert property (s_rd_ctrl |=> (o_rdata & ~`STC_CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bit read as one");
  AST_GATE_RD: assert property (s_rd_ctrl |=> !(o_rdata[1] && o_rdata[6]))
    else $error("gate bit read as one with pin source");
  AST_CTRL_RB: assert property (s_wr_ctrl ##1 s_rd_ctrl |=> o_rdata ==
    ($past(i_wdata, 2) & `STC_CTRL_MASK & ($past(i_wdata[1], 2) ? 16'hFFBF : 16'hFFFF)))
    else $error("control readback mismatch");
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  AST_FLAG_CLR: assert property ($fell(o_timer_event_flag) && $past(!i_sys_rst) |->
    $past(i_wr && i_addr == `STC_ADDR_STATUS && !i_wdata[0]))
    else $error("flag dropped without a clearing write");
  AST_SYNC: assert property ((!i_sleep_mode && $stable(i_count_input_pin)) [*3] |->
    o_gate_sampled == i_count_input_pin) else $error("synchronised level wrong");
  AST_FREEZE: assert property ($past(i_sleep_mode) && $past(!i_sys_rst) |->
    $stable(o_gate_sampled)) else $error("synchroniser moved in sleep");
  AST_FLAG_SLEEP: assert property ($rose(o_timer_event_flag) |-> !$past(i_sleep_mode))
    else $error("flag set during sleep");
endmodule
bind stc_timer stc_timer_checker i_chk (.*);

/* testbench/stc_timer_tb.sv */
`timescale 1ns/100ps
module stc_timer_tb;
  reg         i_clk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg  [1:0]  i_addr = 2'h0;
  reg  [15:0] i_wdata = 16'h0000;
  reg         i_wr = 1'b0;
  reg         i_rd = 1'b0;
  reg         ld = 1'b0;
  reg  [3:0]  npul = 4'h0;
  reg         lvl = 1'b0;
  reg         idl = 1'b0;
  reg         slp = 1'b0;
  reg         pend = 1'b0;
  reg  [1:0]  pend_a = 2'h0;
  reg  [15:0] xp;
  wire [15:0] o_rdata;
  wire        pin;
  wire        flag;
  reg  [15:0] exp_q[$];
  reg  [15:0] w;
  integer     num_errors = 0;
  integer     samples_checked = 0;
  integer     k;
  integer     dv;
  always #20 i_clk = ~i_clk;
  stc_pin_source i_stc_pin_source (.i_clk(i_clk), .i_load(ld), .i_pulses(npul),
    .i_level(lvl), .o_pin(pin));
  stc_timer i_stc_timer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_count_input_pin(pin), .i_idle_mode(idl), .i_sleep_mode(slp),
    .o_timer_event_flag(flag), .o_gate_sampled());
  // ----
  // Bus tasks and monitor
  // ----
  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [39:0] nm, input [15:0] seen, input [15:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s exp %h got %h", nm, want, seen);
      end
    end
  endtask
  // Strobes stay up between calls, so back-to-back accesses need no gap
  task wr(input [1:0] a, input [15:0] d);
    begin i_wr <= 1'b1; i_rd <= 1'b0; i_addr <= a; i_wdata <= d; @(posedge i_clk); end
  endtask
  task rd(input [1:0] a, input [15:0] e);
    begin i_rd <= 1'b1; i_wr <= 1'b0; i_addr <= a; exp_q.push_back(e); @(posedge i_clk); end
  endtask
  task idle_n(input integer n);
    begin i_wr <= 1'b0; i_rd <= 1'b0; repeat (n) @(posedge i_clk); end
  endtask
  task pulse(input [3:0] n);
    begin ld <= 1'b1; npul <= n; idle_n(1); ld <= 1'b0; idle_n(8 * n + 4); end
  endtask
  task setup(input [15:0] per);
    begin wr(0, 16'h0000); wr(3, 16'h0000); wr(1, 16'h0000); wr(2, per); end
  endtask
  always @(posedge i_clk) begin
    pend   <= i_rd;
    pend_a <= i_addr;
  end
  // Status reads also compare the flag pin, which is stable at every status read
  always @(negedge i_clk) begin
    if (pend) begin
      xp = exp_q.pop_front();
      chk("rdata", o_rdata, xp);
      if (pend_a == 2'h3) chk("flag", {15'h0000, flag}, xp);
    end
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    num_errors = num_errors + 1;
    close_out;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(86));
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(0, 16'h0000); rd(1, 16'h0000); rd(2, 16'hFFFF); rd(3, 16'h0000);
    $display("test reset done");
    for (k = 0; k < 8; k = k + 1) begin
      w = $urandom;
      if (w[6]) w[1] = 1'b0;
      wr(0, w); rd(0, w & 16'hA072);
    end
    wr(0, 16'h0042); rd(0, 16'h0002);
    $display("test control done");
    setup(16'hFFFF); wr(0, 16'h8000);
    idle_n(9); rd(1, 16'h0009);
    wr(0, 16'h0000); rd(1, 16'h000B);
    idle_n(5); rd(1, 16'h000B);
    wr(1, 16'h1234); rd(1, 16'h1234);
    $display("test count done");
    for (k = 0; k < 4; k = k + 1) begin
      dv = (k == 3) ? 256 : (1 << (3 * k));
      setup(16'h0003); wr(0, 16'h8000 | (k << 4));
      idle_n(3 * dv - 2); rd(3, 16'h0000);
      idle_n(4 * dv + 4); rd(3, 16'h0001);
    end
    $display("test prescale done");
    setup(16'h0003); lvl <= 1'b1; wr(0, 16'h8040);
    idle_n(20); rd(3, 16'h0000);
    lvl <= 1'b0; idle_n(8); rd(3, 16'h0001);
    $display("test gate done");
    setup(16'hFFFF); wr(0, 16'h8002); pulse(5); rd(1, 16'h0005);
    slp <= 1'b1; pulse(3); slp <= 1'b0; idle_n(4); rd(1, 16'h0005);
    idl <= 1'b1; wr(0, 16'hA002); pulse(2); rd(1, 16'h0005);
    wr(0, 16'h8002); pulse(1); rd(1, 16'h0006);
    idl <= 1'b0;
    $display("test pin done");
    idle_n(3);
    close_out;
  end
endmodule
